// >>> res_dev.sv
// Resource handler: user-file directory and simple I/O access
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module res_dev (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  res_link_if.dev link,
  input wire logic [3:0] access_level_in,
  input wire logic file_wr_in,
  input wire logic [3:0] file_slot_in,
  input wire logic file_valid_in,
  input wire logic [63:0] file_name_in,
  input wire logic [3:0] file_rd_lvl_in,
  input wire logic [3:0] file_wr_lvl_in,
  input wire logic [15:0] file_size_in,
  input wire logic [127:0] io_pin_in,
  output logic [127:0] io_pin_out
);
  //**************************************************
  // Helpers
  //**************************************************
  function automatic logic lvl_ok(input logic [3:0] need, input logic [3:0] lvl);
    lvl_ok = (need != res_pkg::LVL_NONE) && (need <= lvl);
  endfunction

  function automatic logic [63:0] def_resp(input logic [7:0] idx, input logic [63:0] name,
      input logic [15:0] sz, input logic [15:0] rl, input logic [15:0] wl,
      input logic [15:0] ovr, input logic [15:0] typ);
    def_resp = 64'h0;
    case (idx)
      8'h00: def_resp = name;
      8'h01: def_resp = {48'h0, sz};
      8'h02: def_resp = {48'h0, rl};
      8'h03: def_resp = {48'h0, wl};
      8'h04: def_resp = {48'h0, ovr};
      8'h05: def_resp = {48'h0, typ};
      default: def_resp = 64'h0;
    endcase
  endfunction

  //**************************************************
  // File table
  //**************************************************
  logic [res_pkg::FILE_SLOTS-1:0] f_valid_r;
  logic [63:0] f_name_r [res_pkg::FILE_SLOTS];
  logic [3:0] f_rl_r [res_pkg::FILE_SLOTS];
  logic [3:0] f_wl_r [res_pkg::FILE_SLOTS];
  logic [15:0] f_size_r [res_pkg::FILE_SLOTS];

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      f_valid_r <= '0;
    end else if (file_wr_in) begin
      f_valid_r[file_slot_in] <= file_valid_in;
    end
  end

  // Contents need no reset; only valid entries are ever looked at
  always_ff @(posedge core_clk_in) begin
    if (file_wr_in) begin
      f_name_r[file_slot_in] <= file_name_in;
      f_rl_r[file_slot_in] <= file_rd_lvl_in;
      f_wl_r[file_slot_in] <= file_wr_lvl_in;
      f_size_r[file_slot_in] <= file_size_in;
    end
  end

  //**************************************************
  // Directory scan
  //**************************************************
  logic [7:0] vis_cnt;
  logic [15:0] filled;
  logic [15:0] empty;
  logic [63:0] sel_name;

  always_comb begin
    vis_cnt = 8'h00;
    filled = 16'h0000;
    sel_name = 64'h0;
    for (int i = 0; i < res_pkg::FILE_SLOTS; i++) begin
      if (f_valid_r[i]) begin
        filled = 16'(filled + f_size_r[i] + res_pkg::FILE_HDR_BYTES);
        if (lvl_ok(f_rl_r[i], access_level_in) || lvl_ok(f_wl_r[i], access_level_in)) begin
          vis_cnt = 8'(vis_cnt + 8'h01);
          if (vis_cnt == link.off_low) begin
            sel_name = f_name_r[i];
          end
        end
      end
    end
    // Saturates rather than wrapping if the table overfills the store
    empty = (filled > res_pkg::STORE_BYTES) ? 16'h0000 : 16'(res_pkg::STORE_BYTES - filled);
  end

  //**************************************************
  // Input synchroniser
  //**************************************************
  logic [127:0] sync1_r;
  logic [127:0] sync2_r;
  logic [127:0] sync3_r;
  logic [127:0] io_val_r;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      io_val_r <= '0;
    end else begin
      sync1_r <= io_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      io_val_r <= (sync2_r & sync3_r) | (io_val_r & (sync2_r ^ sync3_r));
    end
  end

  //**************************************************
  // Transaction decode
  //**************************************************
  logic [9:0] resource_identifier;
  logic is_rd;
  logic [6:0] io_num;
  logic [7:0] io_lvl;
  logic [63:0] resp;
  logic resp_err;
  logic [7:0] resp_code;
  logic io_wr;

  assign resource_identifier = {link.addr_high[1:0], link.addr_low};
  assign is_rd = link.addr_high[res_pkg::ADDR_H_READ_BIT];
  assign io_num = link.off_low[6:0];
  assign io_lvl = link.wr_buf[31:24];

  always_comb begin
    resp = 64'h0;
    resp_err = 1'b0;
    resp_code = 8'h00;
    io_wr = 1'b0;
    if (link.off_high[res_pkg::OFF_H_DEF_BIT]) begin
      if (!is_rd) begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_NO_ACCESS;
      end else if (resource_identifier == res_pkg::RID_DIR) begin
        resp = def_resp(link.off_low, res_pkg::DIR_NAME, res_pkg::DIR_SIZE, res_pkg::DIR_RD_LVL,
          res_pkg::DIR_WR_LVL, res_pkg::DIR_OVERRUN, res_pkg::DIR_TYPE);
      end else if (resource_identifier == res_pkg::RID_SIO) begin
        resp = def_resp(link.off_low, res_pkg::SIO_NAME, res_pkg::SIO_SIZE, res_pkg::SIO_RD_LVL,
          res_pkg::SIO_WR_LVL, res_pkg::SIO_OVERRUN, res_pkg::SIO_TYPE);
      end else begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_NO_RESOURCE;
      end
    end else if (resource_identifier == res_pkg::RID_DIR) begin
      if (!is_rd) begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_NO_ACCESS;
      end else if (link.off_low == 8'h00) begin
        resp = {16'h0000, filled, empty, 8'h00, vis_cnt};
      end else begin
        resp = sel_name;
      end
    end else if (resource_identifier == res_pkg::RID_SIO) begin
      if (link.off_low[7]) begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_DIRECTION;
      end else if (is_rd) begin
        if (!res_pkg::IO_IS_INPUT[io_num]) begin
          resp_err = 1'b1;
          resp_code = res_pkg::ERR_DIRECTION;
        end else begin
          resp = {32'h0, 7'h00, io_val_r[io_num], 24'h000000};
        end
      end else if (!res_pkg::IO_IS_OUTPUT[io_num]) begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_DIRECTION;
      end else if (io_lvl != res_pkg::IO_LEVEL_0 && io_lvl != res_pkg::IO_LEVEL_1) begin
        resp_err = 1'b1;
        resp_code = res_pkg::ERR_BAD_VALUE;
      end else begin
        io_wr = 1'b1;
      end
    end else begin
      resp_err = 1'b1;
      resp_code = res_pkg::ERR_NO_RESOURCE;
    end
  end

  //**************************************************
  // Completion
  //**************************************************
  logic pend_r;
  logic done_r;
  logic err_r;
  logic [7:0] code_r;
  logic [63:0] rd_buf_r;
  logic [127:0] io_out_r;

  // The request fields are read one cycle after the strobe; the master holds them until done
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      code_r <= 8'h00;
      rd_buf_r <= 64'h0;
    end else if (link.req) begin
      pend_r <= 1'b1;
      done_r <= 1'b0;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      done_r <= 1'b1;
      if (link.ctrl == res_pkg::CTRL_START) begin
        err_r <= resp_err;
        code_r <= resp_code;
        rd_buf_r <= resp;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_out_r <= '0;
    end else if (!link.req && pend_r && link.ctrl == res_pkg::CTRL_START && io_wr) begin
      io_out_r[io_num] <= io_lvl[0];
    end
  end

  assign link.done = done_r;
  assign link.err = err_r;
  assign link.err_code = code_r;
  assign link.rd_buf = rd_buf_r;
  assign io_pin_out = io_out_r;
endmodule

// >>> res_pkg.sv
// Constants for the resource handler link and its controller
//**************************************************
// Contract
//**************************************************
package res_pkg;
  //**************************************************
  // Link fields
  //**************************************************
  localparam logic [9:0] RID_DIR = 10'h134;
  localparam logic [9:0] RID_SIO = 10'h200;
  localparam int ADDR_H_READ_BIT = 6;
  localparam int OFF_H_DEF_BIT = 7;
  localparam logic [7:0] CTRL_START = 8'h01;
  localparam logic [7:0] ERR_DIRECTION = 8'h41;
  localparam logic [7:0] ERR_NO_RESOURCE = 8'h40;
  localparam logic [7:0] ERR_NO_ACCESS = 8'h42;
  localparam logic [7:0] ERR_BAD_VALUE = 8'h43;
  //**************************************************
  // Defining values
  //**************************************************
  localparam logic [63:0] DIR_NAME = 64'h0000_0000_0044_4952;
  localparam logic [15:0] DIR_SIZE = 16'h0008;
  localparam logic [15:0] DIR_RD_LVL = 16'h0000;
  localparam logic [15:0] DIR_WR_LVL = 16'h000F;
  localparam logic [15:0] DIR_OVERRUN = 16'h0082;
  localparam logic [15:0] DIR_TYPE = 16'h0018;
  // Name value is arbitrary
  localparam logic [63:0] SIO_NAME = 64'h4F49_454C_504D_4953;
  localparam logic [15:0] SIO_SIZE = 16'h0004;
  localparam logic [15:0] SIO_RD_LVL = 16'h0000;
  localparam logic [15:0] SIO_WR_LVL = 16'h0000;
  localparam logic [15:0] SIO_OVERRUN = 16'h0046;
  localparam logic [15:0] SIO_TYPE = 16'h0014;
  //**************************************************
  // File store and I/O
  //**************************************************
  localparam int FILE_SLOTS = 16;
  localparam logic [3:0] LVL_NONE = 4'hF;
  localparam logic [15:0] STORE_BYTES = 16'h2000;
  localparam logic [15:0] FILE_HDR_BYTES = 16'h0010;
  localparam logic [7:0] IO_LEVEL_0 = 8'h00;
  localparam logic [7:0] IO_LEVEL_1 = 8'h01;
  localparam logic [127:0] IO_IS_INPUT = 128'h0000_0000_0000_0000_0000_0000_0000_00F0;
  localparam logic [127:0] IO_IS_OUTPUT = 128'h0000_0000_0000_0000_0000_0000_0000_000F;
  //**************************************************
  // Controller registers, word index
  //**************************************************
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_OFFSET = 4'h1;
  localparam logic [3:0] REG_BUF_LO = 4'h2;
  localparam logic [3:0] REG_BUF_HI = 4'h3;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_RES_LO = 4'h6;
  localparam logic [3:0] REG_RES_HI = 4'h7;
  localparam logic [3:0] REG_IRQ_STS = 4'h8;
  localparam logic [3:0] REG_IRQ_MSK = 4'h9;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_LAUNCH = 3'h2,
    H_WAIT = 3'h4
  } host_state_t;
endpackage

// >>> res_link_if.sv
// Link between the drive-side master and the resource handler
`timescale 1ns/1ps
interface res_link_if;
  logic req;
  logic [63:0] wr_buf;
  logic [7:0] addr_high;
  logic [7:0] addr_low;
  logic [7:0] off_high;
  logic [7:0] off_low;
  logic [7:0] ctrl;
  logic done;
  logic err;
  logic [7:0] err_code;
  logic [63:0] rd_buf;
  modport dev (
    input req, wr_buf, addr_high, addr_low, off_high, off_low, ctrl,
    output done, err, err_code, rd_buf
  );
  modport host (
    output req, wr_buf, addr_high, addr_low, off_high, off_low, ctrl,
    input done, err, err_code, rd_buf
  );
endinterface

// >>> res_host.sv
// Drive-side master: Avalon-MM registers to resource transactions
`timescale 1ns/1ps
module res_host (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  res_link_if.host link,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out
);
  //**************************************************
  // Bus slave
  //**************************************************
  logic ack_r;
  logic acc_wr;
  logic sts_clr;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic [15:0] addr_r;
  logic [15:0] off_r;
  logic [63:0] buf_r;
  logic [7:0] ctrl_r;
  logic [63:0] res_r;
  logic err_r;
  logic [7:0] code_r;
  logic [1:0] irq_sts_r;
  logic [1:0] irq_msk_r;
  res_pkg::host_state_t st_r;

  // One wait cycle on every access; read data is registered in it
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
  assign acc_wr = avs_write_in && ack_r;
  // Clear on the edge that captures read data, so an event there survives to the next read
  assign sts_clr = avs_read_in && !ack_r && avs_address_in == res_pkg::REG_IRQ_STS;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in || avs_write_in) && !ack_r;
    end
  end

  always_comb begin
    case (avs_address_in)
      res_pkg::REG_ADDR: rd_mux = {16'h0000, addr_r};
      res_pkg::REG_OFFSET: rd_mux = {16'h0000, off_r};
      res_pkg::REG_BUF_LO: rd_mux = buf_r[31:0];
      res_pkg::REG_BUF_HI: rd_mux = buf_r[63:32];
      res_pkg::REG_CTRL: rd_mux = {24'h000000, ctrl_r};
      res_pkg::REG_STATUS: rd_mux = {16'h0000, code_r, 5'h00, err_r, st_r == res_pkg::H_IDLE, st_r != res_pkg::H_IDLE};
      res_pkg::REG_RES_LO: rd_mux = res_r[31:0];
      res_pkg::REG_RES_HI: rd_mux = res_r[63:32];
      res_pkg::REG_IRQ_STS: rd_mux = {30'h0, irq_sts_r};
      res_pkg::REG_IRQ_MSK: rd_mux = {30'h0, irq_msk_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 32'h0;
    end else if (avs_read_in && !ack_r) begin
      rdata_r <= rd_mux;
    end
  end
  assign avs_readdata_out = rdata_r;

  // Request fields cannot change while a transaction is open
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_r <= 16'h0000;
      off_r <= 16'h0000;
      buf_r <= 64'h0;
      ctrl_r <= 8'h00;
      irq_msk_r <= 2'h0;
    end else if (acc_wr) begin
      if (st_r == res_pkg::H_IDLE) begin
        case (avs_address_in)
          res_pkg::REG_ADDR: addr_r <= avs_writedata_in[15:0];
          res_pkg::REG_OFFSET: off_r <= avs_writedata_in[15:0];
          res_pkg::REG_BUF_LO: buf_r[31:0] <= avs_writedata_in;
          res_pkg::REG_BUF_HI: buf_r[63:32] <= avs_writedata_in;
          res_pkg::REG_CTRL: ctrl_r <= avs_writedata_in[7:0];
          default: ;
        endcase
      end
      if (avs_address_in == res_pkg::REG_IRQ_MSK) begin
        irq_msk_r <= avs_writedata_in[1:0];
      end
    end
  end

  //**************************************************
  // Transaction sequencer
  //**************************************************
  logic launch;
  logic finish;
  assign launch = acc_wr && avs_address_in == res_pkg::REG_CTRL && st_r == res_pkg::H_IDLE;
  assign finish = st_r == res_pkg::H_WAIT && link.done;

  // Old done stays high until the device sees the strobe, so wait for it to drop first
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= res_pkg::H_IDLE;
    end else begin
      case (st_r)
        res_pkg::H_IDLE: if (launch) begin
          st_r <= res_pkg::H_LAUNCH;
        end
        res_pkg::H_LAUNCH: if (!link.done) begin
          st_r <= res_pkg::H_WAIT;
        end
        res_pkg::H_WAIT: if (link.done) begin
          st_r <= res_pkg::H_IDLE;
        end
        default: st_r <= res_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_r <= 64'h0;
      err_r <= 1'b0;
      code_r <= 8'h00;
    end else if (finish) begin
      res_r <= link.rd_buf;
      err_r <= link.err;
      code_r <= link.err_code;
    end
  end

  //**************************************************
  // Interrupts
  //**************************************************
  localparam int IRQ_DONE = res_pkg::IRQ_DONE_BIT;
  localparam int IRQ_ERR = res_pkg::IRQ_ERR_BIT;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_sts_r <= 2'h0;
    end else begin
      irq_sts_r[IRQ_DONE] <= finish || (irq_sts_r[IRQ_DONE] && !sts_clr);
      irq_sts_r[IRQ_ERR] <= (finish && link.err) || (irq_sts_r[IRQ_ERR] && !sts_clr);
    end
  end
  assign irq_out = |(irq_sts_r & irq_msk_r);

  //**************************************************
  // Link drive
  //**************************************************
  logic req_r;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_r <= 1'b0;
    end else begin
      req_r <= launch;
    end
  end

  assign link.req = req_r;
  assign link.addr_high = addr_r[15:8];
  assign link.addr_low = addr_r[7:0];
  assign link.off_high = off_r[15:8];
  assign link.off_low = off_r[7:0];
  assign link.wr_buf = buf_r;
  assign link.ctrl = ctrl_r;
endmodule

// >>> res_link_assertions.sv
// Checker for the link between the resource master and the resource handler
`timescale 1ns/1ps
module res_link_assertions (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic req,
  input wire logic [63:0] wr_buf,
  input wire logic [7:0] addr_high,
  input wire logic [7:0] addr_low,
  input wire logic [7:0] off_high,
  input wire logic [7:0] off_low,
  input wire logic [7:0] ctrl,
  input wire logic done,
  input wire logic err,
  input wire logic [7:0] err_code,
  input wire logic [63:0] rd_buf
);
  //**************************************************
  // Decoded request fields
  //**************************************************
  wire logic [9:0] resource_identifier = {addr_high[1:0], addr_low};
  wire logic rd_op = addr_high[6];
  wire logic dflt = off_high[7];
  wire logic sio_wr = !rd_op && (resource_identifier == 10'h200) && !dflt;
  wire logic dir_sum = rd_op && (resource_identifier == 10'h134) && !dflt && (off_low == 8'h00);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_done_answer: assert property (req |=> !done ##1 done)
    else $error("done did not answer the request on time");
  a_ctrl_start: assert property (req |-> ctrl == res_pkg::CTRL_START)
    else $error("request launched with a wrong control value");
  // Fields must not move while the handler is still working on them
  a_fields_held: assert property (req |=> ($stable(addr_high) && $stable(addr_low) && $stable(off_low) && $stable(wr_buf))[*2])
    else $error("request fields moved before done");
  a_done_stands: assert property (done && !req |=> done)
    else $error("done dropped without a new request");
  a_sum_reserved: assert property ($rose(done) && dir_sum |-> rd_buf[63:48] == 16'h0000 && rd_buf[15:8] == 8'h00 && !err)
    else $error("summary reserved bytes not zero");
  a_store_total: assert property ($rose(done) && dir_sum |-> rd_buf[47:32] + rd_buf[31:16] == res_pkg::STORE_BYTES)
    else $error("filled and empty store do not add up");
  a_dir_overrun: assert property ($rose(done) && rd_op && resource_identifier == 10'h134 && dflt && off_low == 8'h04 |-> rd_buf == 64'h0082)
    else $error("directory overrun value wrong");
  a_sio_overrun: assert property ($rose(done) && rd_op && resource_identifier == 10'h200 && dflt && off_low == 8'h04 |-> rd_buf == 64'h0046)
    else $error("simple I/O overrun value wrong");
  a_io_range: assert property ($rose(done) && sio_wr && off_low[7] |-> err && err_code == 8'h41)
    else $error("I/O number above range not refused");
  a_io_input: assert property ($rose(done) && sio_wr && !off_low[7] && res_pkg::IO_IS_INPUT[off_low[6:0]] |-> err && err_code == 8'h41)
    else $error("write to an input not refused");
  a_io_read_byte: assert property ($rose(done) && rd_op && resource_identifier == 10'h200 && !dflt && !err |-> rd_buf[63:25] == 39'h0 && rd_buf[23:0] == 24'h0)
    else $error("I/O read level outside byte three");
  c_summary: cover property ($rose(done) && dir_sum);
  c_error: cover property ($rose(done) && err);
  c_defining: cover property ($rose(done) && dflt);
endmodule

// >>> feedback_resource_dir_io_bench.sv
// Bench: both link ends joined, driven through the Avalon-MM registers
`timescale 1ns/1ps
module feedback_resource_dir_io_bench;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [3:0] access_level = 4'h0;
  logic file_wr = 1'b0;
  logic file_valid = 1'b0;
  logic [3:0] file_slot = 4'h0;
  logic [63:0] file_name = 64'h0;
  logic [3:0] file_rd_lvl = 4'h0;
  logic [3:0] file_wr_lvl = 4'h0;
  logic [15:0] file_size = 16'h0;
  logic [127:0] io_pin = 128'h20;
  logic [127:0] io_level;
  logic [63:0] res;
  logic [31:0] rdv;
  logic [31:0] stat;
  logic [15:0] dir_def [5] = '{16'h0008, 16'h0000, 16'h000F, 16'h0082, 16'h0018};
  logic [15:0] sio_def [5] = '{16'h0004, 16'h0000, 16'h0000, 16'h0046, 16'h0014};
  int bad_count = 0;
  int comparisons = 0;
  always #10 core_clk_in = ~core_clk_in;
  res_link_if u_res_link_if ();
  res_host u_res_host (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(u_res_link_if.host),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .irq_out(irq));
  res_dev u_res_dev (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link(u_res_link_if.dev),
    .access_level_in(access_level), .file_wr_in(file_wr), .file_slot_in(file_slot),
    .file_valid_in(file_valid), .file_name_in(file_name), .file_rd_lvl_in(file_rd_lvl),
    .file_wr_lvl_in(file_wr_lvl), .file_size_in(file_size), .io_pin_in(io_pin), .io_pin_out(io_level));
  res_link_assertions u_res_link_assertions (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .req(u_res_link_if.req), .wr_buf(u_res_link_if.wr_buf), .addr_high(u_res_link_if.addr_high),
    .addr_low(u_res_link_if.addr_low), .off_high(u_res_link_if.off_high), .off_low(u_res_link_if.off_low),
    .ctrl(u_res_link_if.ctrl), .done(u_res_link_if.done), .err(u_res_link_if.err),
    .err_code(u_res_link_if.err_code), .rd_buf(u_res_link_if.rd_buf));
  //**************************************************
  // Access tasks
  //**************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One idle edge after each access, so no strobe is set twice in one step
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk_in); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic xfer(input logic [15:0] adr, input logic [15:0] off, input logic [63:0] b);
    av(1'b1, res_pkg::REG_ADDR, {16'h0, adr});
    av(1'b1, res_pkg::REG_OFFSET, {16'h0, off});
    av(1'b1, res_pkg::REG_BUF_LO, b[31:0]);
    av(1'b1, res_pkg::REG_BUF_HI, b[63:32]);
    av(1'b1, res_pkg::REG_CTRL, 32'h1);
    // No poll limit of its own; a hang is left to the watchdog
    do begin
      av(1'b0, res_pkg::REG_STATUS, 32'h0);
    end while (rdv[1:0] !== 2'b10);
    stat = rdv;
    av(1'b0, res_pkg::REG_RES_LO, 32'h0);
    res[31:0] = rdv;
    av(1'b0, res_pkg::REG_RES_HI, 32'h0);
    res[63:32] = rdv;
  endtask
  task automatic want_err(input logic [7:0] c);
    check({55'h0, stat[2], stat[15:8]}, {55'h0, 1'b1, c});
  endtask
  task automatic add_file(input logic [3:0] s, input logic [63:0] nm, input logic [3:0] rl, input logic [3:0] wl,
                          input logic [15:0] sz);
    file_slot <= s;
    file_name <= nm;
    file_rd_lvl <= rl;
    file_wr_lvl <= wl;
    file_size <= sz;
    file_valid <= 1'b1;
    file_wr <= 1'b1;
    @(posedge core_clk_in);
    file_wr <= 1'b0;
    @(posedge core_clk_in);
  endtask
  //**************************************************
  // Test sequence
  //**************************************************
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    av(1'b0, 4'hF, 32'h0);
    check({32'h0, rdv}, 64'h0);
    av(1'b1, res_pkg::REG_IRQ_MSK, 32'h1);
    xfer(16'h7D34, 16'h0000, 64'h0);
    check(res, 64'h0000_0000_2000_0000);
    check({63'h0, stat[2]}, 64'h0);
    check({63'h0, irq}, 64'h1);
    av(1'b0, res_pkg::REG_IRQ_STS, 32'h0);
    check({32'h0, rdv}, 64'h1);
    check({63'h0, irq}, 64'h0);
    av(1'b1, res_pkg::REG_IRQ_MSK, 32'h0);
    add_file(4'h0, 64'h0000_0041_454C_4946, 4'h0, 4'h1, 16'h0035);
    add_file(4'h1, 64'h0000_0000_4F47_4F4C, 4'h3, 4'hF, 16'h0100);
    xfer(16'h7D34, 16'h0000, 64'h0);
    check({56'h0, res[7:0]}, 64'h1);
    check({63'h0, irq}, 64'h0);
    av(1'b0, res_pkg::REG_IRQ_STS, 32'h0);
    check({62'h0, rdv[1:0]}, 64'h1);
    xfer(16'h7D34, 16'h0001, 64'h0);
    check(res, 64'h0000_0041_454C_4946);
    xfer(16'h7D34, 16'h0002, 64'h0);
    check(res, 64'h0);
    access_level <= 4'h3;
    xfer(16'h7D34, 16'h0000, 64'h0);
    check(res, 64'h0000_0155_1EAB_0002);
    xfer(16'h7D34, 16'h5502, 64'h0);
    check(res, 64'h0000_0000_4F47_4F4C);
    for (int i = 1; i < 6; i++) begin
      xfer(16'h7D34, {8'h80, 8'(i)}, 64'h0);
      check(res, {48'h0, dir_def[i-1]});
      xfer(16'h7A00, {8'h80, 8'(i)}, 64'h0);
      check(res, {48'h0, sio_def[i-1]});
    end
    // Directory write level is 15, so a write is refused
    xfer(16'h3D34, 16'h0000, 64'h0);
    want_err(8'h42);
    xfer(16'h3A00, 16'h0003, 64'h0000_0000_0100_0000);
    check({63'h0, io_level[3]}, 64'h1);
    xfer(16'h3A00, 16'h0003, 64'h0);
    check({63'h0, io_level[3]}, 64'h0);
    xfer(16'h3A00, 16'h0002, 64'h0000_0000_0200_0000);
    want_err(8'h43);
    xfer(16'h3A00, 16'h0005, 64'h0000_0000_0100_0000);
    want_err(8'h41);
    av(1'b0, res_pkg::REG_IRQ_STS, 32'h0);
    check({62'h0, rdv[1:0]}, 64'h3);
    xfer(16'h3A00, 16'h0080, 64'h0000_0000_0100_0000);
    want_err(8'h41);
    xfer(16'h7A00, 16'h0000, 64'h0);
    want_err(8'h41);
    xfer(16'h7A00, 16'h0005, 64'h0);
    check(res, 64'h0000_0000_0100_0000);
    xfer(16'h7A00, 16'h0004, 64'h0);
    check(res, 64'h0);
    close_out();
  end
  // Whole run needs about 730 cycles; 20,000 cycles means a hang
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule
